// file: include/strobe_map.vh
// Behaviour
// - Controller writes assert each lane write strobe only for valid data lanes.
// - Controller read asserts the read output enable during the strobe phase.
// - Machine B byte selects follow its pattern, asserted only on valid lanes.
// - Machine A byte selects follow its pattern, lane 0 bits 0-7 upward, valid only.
// - Card I/O read strobe asserts only for card reads of I/O space.
// - Card I/O write strobe asserts only for card writes of I/O space.
// - Card memory read enable asserts for card reads of memory space.
// - Card memory write enable asserts for card writes of memory space.
// - Aux lines 0-1, and 2-3 while cs_pins_mode is low, show machine A or B programmed value during its transfer.
// - Shared pins act as chip selects 2 and 3, double drive selectable each.
`ifndef STROBE_MAP_VH
`define STROBE_MAP_VH

// Request word layout
`define REQ_WIDTH 18
`define REQ_LANES_LSB 0
`define REQ_LANES_MSB 3
`define REQ_PAT_LSB 4
`define REQ_PAT_MSB 7
`define REQ_AUX_LSB 8
`define REQ_AUX_MSB 11
`define REQ_READ_BIT 12
`define REQ_IO_BIT 13
`define REQ_MACH_LSB 14
`define REQ_MACH_MSB 15
`define REQ_CS_LSB 16
`define REQ_CS_MSB 17

// Machine codes
`define MACH_GENERAL 2'h0
`define MACH_USER_A 2'h1
`define MACH_USER_B 2'h2
`define MACH_CARD 2'h3

// Phase lengths in clock cycles
`define SETUP_CYCLES 4'h1
`define STROBE_CYCLES 4'h2
`define HOLD_CYCLES 4'h1

// Request buffer depth
`define FIFO_DEPTH 4

`endif

// file: core/strobe_fifo.v
`timescale 1ns/1ps
`default_nettype none

module strobe_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  // Full level and last index, cut to the pointer widths on purpose
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [31:0] LAST_W = DEPTH - 1;
  localparam [AW:0] FULL = DEPTH_W[AW:0];
  localparam [AW-1:0] LAST = LAST_W[AW-1:0];

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign in_ready = (count_q != FULL);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // strobe_fifo

`default_nettype wire

// file: core/byte_lane_strobe_outputs.v
`timescale 1ns/1ps
`default_nettype none
`include "strobe_map.vh"

module byte_lane_strobe_outputs #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter [3:0] SETUP_CYC = `SETUP_CYCLES,
  parameter [3:0] STROBE_CYC = `STROBE_CYCLES,
  parameter [3:0] HOLD_CYC = `HOLD_CYCLES
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Transfer requests from the controller machines
  input wire req_valid,
  output wire req_ready,
  input wire [1:0] req_machine,
  input wire req_read,
  input wire req_io_space,
  input wire [3:0] req_lanes_valid,
  input wire [3:0] req_select_pattern,
  input wire [3:0] req_aux_value,
  input wire [1:0] req_cs_hit,
  // System configuration
  input wire cs_pins_mode,
  input wire cs2_double_drive_cfg,
  input wire cs3_double_drive_cfg,
  // Status
  output wire busy,
  output reg transfer_done_q,
  // Shared lane pins, active low
  output reg lane0_pin_n_q,
  output reg lane1_pin_n_q,
  output reg lane2_pin_n_q,
  output reg lane3_pin_n_q,
  // Machine A lane select pins, active low
  output reg [3:0] machine_a_lane_selects_n_q,
  // Aux line 0 and read enable / aux line 1 pins
  output reg aux0_pin_n_q,
  output reg read_enable_aux1_pin_n_q,
  // Aux lines 2-3 or chip selects 2-3
  output reg [1:0] aux23_cs_pin_n_q,
  output reg cs2_double_drive_q,
  output reg cs3_double_drive_q
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_STROBE = 2'h2;
  localparam ST_HOLD = 2'h3;

  // Request buffer
  wire [`REQ_WIDTH-1:0] fill_word;
  wire [`REQ_WIDTH-1:0] head_word;
  wire head_valid;
  wire head_take;

  assign fill_word = {req_cs_hit, req_machine, req_io_space, req_read,
    req_aux_value, req_select_pattern, req_lanes_valid};

  strobe_fifo #(
    .WIDTH(`REQ_WIDTH),
    .DEPTH(DEPTH),
    .AW(2)
  ) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(fill_word),
    .out_valid(head_valid),
    .out_ready(head_take),
    .out_data(head_word)
  );

  // Sequencer
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg [`REQ_WIDTH-1:0] cur_q;
  reg done_d;

  // Only take a new request from idle, so the buffer stalls while a transfer runs
  assign head_take = (state_q == ST_IDLE) && head_valid;
  assign busy = (state_q != ST_IDLE) || head_valid;

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (head_valid) begin
          state_d = ST_SETUP;
          cnt_d = SETUP_CYC;
        end
      end
      ST_SETUP: begin
        if (cnt_q <= 4'h1) begin
          state_d = ST_STROBE;
          cnt_d = STROBE_CYC;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_STROBE: begin
        if (cnt_q <= 4'h1) begin
          state_d = ST_HOLD;
          cnt_d = HOLD_CYC;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_HOLD: begin
        if (cnt_q <= 4'h1) begin
          state_d = ST_IDLE;
          cnt_d = 4'h0;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      cur_q <= {`REQ_WIDTH{1'b0}};
      transfer_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      transfer_done_q <= done_d;
      if (head_take) begin
        cur_q <= head_word;
      end
    end
  end

  // Decode of the transfer in progress, seen from the next state
  wire [1:0] mach;
  wire rd;
  wire io;
  wire [3:0] lanes;
  wire [3:0] pat;
  wire [3:0] aux;
  wire [1:0] cs_hit;
  wire [`REQ_WIDTH-1:0] nxt_word;
  wire in_access;
  wire in_strobe;
  wire is_general;
  wire is_user_a;
  wire is_user_b;
  wire is_card;
  wire is_user;

  // Latch-free view of the word that the next state will act on
  assign nxt_word = head_take ? head_word : cur_q;
  assign mach = nxt_word[`REQ_MACH_MSB:`REQ_MACH_LSB];
  assign rd = nxt_word[`REQ_READ_BIT];
  assign io = nxt_word[`REQ_IO_BIT];
  assign lanes = nxt_word[`REQ_LANES_MSB:`REQ_LANES_LSB];
  assign pat = nxt_word[`REQ_PAT_MSB:`REQ_PAT_LSB];
  assign aux = nxt_word[`REQ_AUX_MSB:`REQ_AUX_LSB];
  assign cs_hit = nxt_word[`REQ_CS_MSB:`REQ_CS_LSB];

  assign in_access = (state_d != ST_IDLE);
  assign in_strobe = (state_d == ST_STROBE);
  assign is_general = in_access && (mach == `MACH_GENERAL);
  assign is_user_a = in_access && (mach == `MACH_USER_A);
  assign is_user_b = in_access && (mach == `MACH_USER_B);
  assign is_card = in_access && (mach == `MACH_CARD);
  assign is_user = is_user_a || is_user_b;

  // Per-lane strobes, active high internally
  wire [3:0] write_lane_strobe;
  wire [3:0] machine_b_lane_select;
  wire [3:0] machine_a_lane_select;
  wire [3:0] card_strobe;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      // Write strobe for lane g, only when that lane carries data
      assign write_lane_strobe[g] = is_general && !rd && in_strobe && lanes[g];
      // Machine B select: programmed pattern qualified by lane validity
      assign machine_b_lane_select[g] = is_user_b && in_strobe && pat[g] && lanes[g];
      // Machine A select: lane g covers data bits 8g to 8g+7
      assign machine_a_lane_select[g] = is_user_a && in_strobe && pat[g] && lanes[g];
    end
  endgenerate

  wire write_lane0_strobe;
  wire write_lane1_strobe;
  wire write_lane2_strobe;
  wire write_lane3_strobe;
  wire machine_b_lane0_select;
  wire machine_b_lane2_select;
  wire machine_b_lane3_select;
  wire card_io_read_strobe;
  wire card_io_write_strobe;
  wire card_mem_read_enable;
  wire card_mem_write_enable;
  wire general_read_enable;

  assign write_lane0_strobe = write_lane_strobe[0];
  assign write_lane1_strobe = write_lane_strobe[1];
  assign write_lane2_strobe = write_lane_strobe[2];
  assign write_lane3_strobe = write_lane_strobe[3];
  assign machine_b_lane0_select = machine_b_lane_select[0];
  assign machine_b_lane2_select = machine_b_lane_select[2];
  assign machine_b_lane3_select = machine_b_lane_select[3];

  // Card strobes are not lane qualified; space selects the strobe
  assign card_io_read_strobe = is_card && in_strobe && rd && io;
  assign card_io_write_strobe = is_card && in_strobe && !rd && io;
  assign card_mem_read_enable = is_card && in_strobe && rd && !io;
  assign card_mem_write_enable = is_card && in_strobe && !rd && !io;
  assign card_strobe = {card_mem_write_enable, card_mem_read_enable,
    card_io_write_strobe, card_io_read_strobe};

  // Read enable covers the strobe phase of a controller read
  assign general_read_enable = is_general && rd && in_strobe;

  // Aux lines show the programmed level for the whole access
  wire [3:0] machine_a_aux_lines;
  wire [3:0] machine_b_aux_lines;
  wire [1:0] machine_a_aux_lines_2_3;
  wire [1:0] machine_b_aux_lines_2_3;
  wire [3:0] aux_level;

  assign machine_a_aux_lines = is_user_a ? aux : 4'hf;
  assign machine_b_aux_lines = is_user_b ? aux : 4'hf;
  assign machine_a_aux_lines_2_3 = machine_a_aux_lines[3:2];
  assign machine_b_aux_lines_2_3 = machine_b_aux_lines[3:2];
  assign aux_level = machine_a_aux_lines & machine_b_aux_lines;

  // Pin next values, active low
  reg [3:0] lane_pin_d;
  reg [3:0] sel_a_pin_d;
  reg aux0_pin_d;
  reg aux1_pin_d;
  reg [1:0] aux23_pin_d;

  always @* begin
    lane_pin_d = 4'hf;
    sel_a_pin_d = ~machine_a_lane_select;
    aux0_pin_d = is_user ? aux_level[0] : 1'b1;
    aux1_pin_d = 1'b1;
    if (is_general) begin
      lane_pin_d = ~{write_lane3_strobe, write_lane2_strobe,
        write_lane1_strobe, write_lane0_strobe};
      aux1_pin_d = ~general_read_enable;
    end else if (is_user_b) begin
      lane_pin_d = ~{machine_b_lane3_select, machine_b_lane2_select,
        machine_b_lane_select[1], machine_b_lane0_select};
      aux1_pin_d = aux_level[1];
    end else if (is_user_a) begin
      aux1_pin_d = aux_level[1];
    end else if (is_card) begin
      lane_pin_d = ~card_strobe;
    end
    if (cs_pins_mode) begin
      // Chip select spans the whole access of a hitting transfer
      aux23_pin_d = ~(cs_hit & {2'b11} & {in_access, in_access});
    end else begin
      aux23_pin_d = machine_a_aux_lines_2_3 & machine_b_aux_lines_2_3;
    end
  end

  always @(posedge clock) begin
    if (!rstn) begin
      // All pins inactive high while in reset
      lane0_pin_n_q <= 1'b1;
      lane1_pin_n_q <= 1'b1;
      lane2_pin_n_q <= 1'b1;
      lane3_pin_n_q <= 1'b1;
      machine_a_lane_selects_n_q <= 4'hf;
      aux0_pin_n_q <= 1'b1;
      read_enable_aux1_pin_n_q <= 1'b1;
      aux23_cs_pin_n_q <= 2'h3;
      cs2_double_drive_q <= 1'b0;
      cs3_double_drive_q <= 1'b0;
    end else begin
      lane0_pin_n_q <= lane_pin_d[0];
      lane1_pin_n_q <= lane_pin_d[1];
      lane2_pin_n_q <= lane_pin_d[2];
      lane3_pin_n_q <= lane_pin_d[3];
      machine_a_lane_selects_n_q <= sel_a_pin_d;
      aux0_pin_n_q <= aux0_pin_d;
      read_enable_aux1_pin_n_q <= aux1_pin_d;
      aux23_cs_pin_n_q <= aux23_pin_d;
      // Drive strength only matters while the pin is a chip select
      cs2_double_drive_q <= cs_pins_mode && cs2_double_drive_cfg;
      cs3_double_drive_q <= cs_pins_mode && cs3_double_drive_cfg;
    end
  end

endmodule // byte_lane_strobe_outputs

`default_nettype wire

// file: sim/strobe_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module strobe_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Watched ports
  input wire logic busy,
  input wire logic transfer_done_q,
  input wire logic lane0_pin_n_q,
  input wire logic lane1_pin_n_q,
  input wire logic lane2_pin_n_q,
  input wire logic lane3_pin_n_q,
  input wire logic [3:0] machine_a_lane_selects_n_q,
  input wire logic aux0_pin_n_q,
  input wire logic read_enable_aux1_pin_n_q,
  input wire logic [1:0] aux23_cs_pin_n_q,
  input wire logic cs_pins_mode,
  input wire logic cs2_double_drive_cfg,
  input wire logic cs3_double_drive_cfg,
  input wire logic cs2_double_drive_q,
  input wire logic cs3_double_drive_q
);
  wire [11:0] pins = {lane3_pin_n_q, lane2_pin_n_q, lane1_pin_n_q, lane0_pin_n_q,
    machine_a_lane_selects_n_q, aux0_pin_n_q, read_enable_aux1_pin_n_q, aux23_cs_pin_n_q};
  wire [1:0] dd_cfg = {cs3_double_drive_cfg, cs2_double_drive_cfg} & {2{cs_pins_mode}};
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_idle_pins_high:
    assert property (!busy |-> &pins) else $error("Pin low while idle");
  chk_drive_follow:
    assert property ($past(rstn) |-> {cs3_double_drive_q, cs2_double_drive_q} == $past(dd_cfg))
    else $error("Double drive mismatch");
  chk_lane0_width:
    assert property ($fell(lane0_pin_n_q) |=> !lane0_pin_n_q ##1 lane0_pin_n_q)
    else $error("Lane strobe width");
  chk_sel_a_width:
    assert property ($fell(machine_a_lane_selects_n_q[0]) |=>
      !machine_a_lane_selects_n_q[0] ##1 machine_a_lane_selects_n_q[0])
    else $error("Select width");
  chk_lane1_done:
    assert property ($fell(lane1_pin_n_q) |-> ##3 transfer_done_q) else $error("Done late");
  chk_aux_span:
    assert property ($fell(aux0_pin_n_q) |-> !aux0_pin_n_q [*4] ##1 aux0_pin_n_q)
    else $error("Aux span");
  chk_cs_span:
    assert property ($fell(aux23_cs_pin_n_q[0]) |-> ##4 transfer_done_q) else $error("CS span");
  chk_done_gap:
    assert property (transfer_done_q |=> !transfer_done_q [*4]) else $error("Done spacing");
  chk_reset_idle:
    assert property (disable iff (1'b0) !rstn |=> &pins && !transfer_done_q
      && !cs2_double_drive_q && !cs3_double_drive_q) else $error("Pins not idle in reset");
  cover property ($fell(lane2_pin_n_q));
  cover property ($fell(machine_a_lane_selects_n_q[3]));
  cover property ($fell(aux23_cs_pin_n_q[1]));
endmodule // strobe_checker
bind byte_lane_strobe_outputs strobe_checker u_strobe_checker (.clock(clock), .rstn(rstn),
  .busy(busy), .transfer_done_q(transfer_done_q), .lane0_pin_n_q(lane0_pin_n_q),
  .lane1_pin_n_q(lane1_pin_n_q), .lane2_pin_n_q(lane2_pin_n_q), .lane3_pin_n_q(lane3_pin_n_q),
  .machine_a_lane_selects_n_q(machine_a_lane_selects_n_q), .aux0_pin_n_q(aux0_pin_n_q),
  .read_enable_aux1_pin_n_q(read_enable_aux1_pin_n_q), .aux23_cs_pin_n_q(aux23_cs_pin_n_q),
  .cs_pins_mode(cs_pins_mode), .cs2_double_drive_cfg(cs2_double_drive_cfg),
  .cs3_double_drive_cfg(cs3_double_drive_cfg), .cs2_double_drive_q(cs2_double_drive_q),
  .cs3_double_drive_q(cs3_double_drive_q));
`default_nettype wire

// file: sim/memory_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module memory_side_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Lane strobes and selects seen by the slaves
  input wire logic [7:0] strobes_n,
  // Lane cycles served
  output logic [15:0] served
);
  // Each low strobe is one lane cycle the slaves act on
  always @(posedge clock) begin
    if (!rstn) begin
      served <= 16'h0;
    end else begin
      served <= served + 16'(8 - $countones(strobes_n));
    end
  end
endmodule // memory_side_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic [17:0] w_q = 18'h0;
  logic [2:0] cfg_q = 3'h0;
  wire req_ready, busy, done, l0, l1, l2, l3, ax0, rd1, dd2, dd3;
  wire [3:0] sel_a;
  wire [1:0] ax23;
  wire [15:0] served;
  wire [11:0] pins = {l3, l2, l1, l0, sel_a, ax0, rd1, ax23};
  int num_errors = 0;
  int samples_checked = 0;
  int stalls = 0;
  logic [23:0] notes[$];
  logic [23:0] note;
  logic [47:0] hist = 48'h0;
  logic [15:0] exp_served = 16'h0;
  always #50 clock = ~clock;
  byte_lane_strobe_outputs u_byte_lane_strobe_outputs (.clock(clock), .rstn(rstn),
    .req_valid(req_valid), .req_ready(req_ready), .req_machine(w_q[15:14]),
    .req_read(w_q[12]), .req_io_space(w_q[13]), .req_lanes_valid(w_q[3:0]),
    .req_select_pattern(w_q[7:4]), .req_aux_value(w_q[11:8]), .req_cs_hit(w_q[17:16]),
    .cs_pins_mode(cfg_q[0]), .cs2_double_drive_cfg(cfg_q[1]), .cs3_double_drive_cfg(cfg_q[2]),
    .busy(busy), .transfer_done_q(done), .lane0_pin_n_q(l0), .lane1_pin_n_q(l1),
    .lane2_pin_n_q(l2), .lane3_pin_n_q(l3), .machine_a_lane_selects_n_q(sel_a),
    .aux0_pin_n_q(ax0), .read_enable_aux1_pin_n_q(rd1), .aux23_cs_pin_n_q(ax23),
    .cs2_double_drive_q(dd2), .cs3_double_drive_q(dd3));
  memory_side_model u_memory_side_model (.clock(clock), .rstn(rstn),
    .strobes_n({l3, l2, l1, l0, sel_a}), .served(served));
  task automatic fail(input string s);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, s);
  endtask
  task automatic stop_test();
    $display("Errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Offer one request, then note the setup/hold and strobe pin patterns
  task automatic push(input logic [17:0] w);
    logic [3:0] ln, sa, ax, sx;
    int n;
    ln = 4'hf;
    sa = 4'hf;
    ax = (w[15:14] == 2'h1 || w[15:14] == 2'h2) ? w[11:8] : 4'hf;
    if (cfg_q[0]) ax[3:2] = ~w[17:16];
    sx = ax;
    case (w[15:14])
      2'h0: if (w[12]) sx[1] = 1'b0; else ln = ~w[3:0];
      2'h1: sa = ~(w[7:4] & w[3:0]);
      2'h2: ln = ~(w[7:4] & w[3:0]);
      default: ln = ~{~w[12] & ~w[13], w[12] & ~w[13],
        ~w[12] & w[13], w[12] & w[13]};
    endcase
    w_q <= w;
    req_valid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (req_ready === 1'b1) break;
      stalls++;
    end
    if (n == 40) begin
      fail("request never taken");
      stop_test();
    end
    notes.push_back({8'hff, ax[0], ax[1], ax[3:2], ln, sa, sx[0], sx[1], sx[3:2]});
    exp_served += 16'(2 * ($countones(~ln) + $countones(~sa)));
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge clock);
      if (busy === 1'b0 && notes.size() == 0) break;
    end
    if (n == 300) begin
      fail("no return to idle");
      stop_test();
    end
  endtask
  // Each finished transfer is judged on setup, strobe and hold cycles
  always @(posedge clock) begin
    if (rstn && done === 1'b1) begin
      if (notes.size() == 0) begin
        fail("unexpected transfer");
      end else begin
        note = notes.pop_front();
        samples_checked++;
        if (hist !== {note[23:12], {2{note[11:0]}}, note[23:12]})
          fail("pin pattern");
      end
    end
    hist <= {hist[35:0], pins};
  end
  initial begin
    logic [17:0] w;
    int k;
    int m;
    void'($urandom(32'hec07));
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    // Reset lands in the middle of a strobe
    push(18'h0000f);
    req_valid <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    samples_checked++;
    if (pins !== 12'hfff || done !== 1'b0) fail("pins active in reset");
    notes.delete();
    exp_served = 16'h0;
    rstn <= 1'b1;
    for (k = 0; k < 2; k++) begin
      cfg_q <= {2'($urandom), k[0]};
      @(posedge clock);
      for (m = 0; m < 16; m++) begin
        w = 18'($urandom);
        w[15:12] = m[3:0];
        push(w);
      end
      req_valid <= 1'b0;
      wait_idle();
      samples_checked++;
      if ({dd3, dd2} !== (cfg_q[2:1] & {2{k[0]}})) fail("double drive");
    end
    samples_checked++;
    if (stalls == 0) fail("buffer never refused");
    samples_checked++;
    if (served !== exp_served) fail("lane cycles served");
    stop_test();
  end
endmodule // tb
`default_nettype wire
